// file: hdl/spief_regs.vh
// Constants of the SPI error and interrupt flag block.
// Assumes it is included by its bare name from the design files.
`ifndef SPIEF_REGS_VH
`define SPIEF_REGS_VH
// Status byte field positions
`define SPIEF_STA_TC_BIT 7
`define SPIEF_STA_WRITE_COLLISION_FLAG_BIT 6
`define SPIEF_STA_SLAVE_SELECT_ERROR_FLAG_BIT 5
`define SPIEF_STA_MODE_FAULT_FLAG_BIT 4
// Control reset values
`define SPIEF_CTL_EN_RST 1'h0
`define SPIEF_CTL_MASTER_SELECT_BIT_RST 1'h0
`define SPIEF_CTL_SLAVE_SELECT_DISABLE_BIT_RST 1'h0
// Control byte field positions
`define SPIEF_CTL_EN_BIT 6
`define SPIEF_CTL_SLAVE_SELECT_DISABLE_BIT_BIT 5
`define SPIEF_CTL_MASTER_SELECT_BIT_BIT 4
// Idle levels of the pins, loaded into their synchronisers at reset
`define SPIEF_SS_IDLE 1'h1
`define SPIEF_SCK_IDLE 1'h0
// Data reset value
`define SPIEF_DATA_RST 8'h00
// Sync depth for pin inputs
`define SPIEF_SYNC_STAGES 2
`endif

// file: hdl/spief_sync.v
// Two-stage synchroniser for a level coming from outside the CLK domain.
// Assumes CLK is free running and SYS_RST synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module spief_sync #(
    parameter [0:0] RST_LEVEL = 1'h1 // Idle level of the pin, so reset makes no false edge
) (
    input wire clk,
    input wire rst,
    input wire d,
    output wire q
);
    reg s1_r; // First stage, read only by the second
    reg s2_r; // Second stage, safe to use
    // Shift the level through two flops
    always @(posedge clk) begin
        if (rst) begin
            s1_r <= RST_LEVEL;
            s2_r <= RST_LEVEL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // spief_sync
`default_nettype wire

// file: hdl/spief_top.v
// Error flags and interrupt requests of an SPI controller.
// Assumes the CPU side gives one-cycle access strobes on CLK, and the
// shifter gives transfer status; slave select and serial clock are pins.
//
// Contract
// - Master, SS enabled, SS low sets fault
// - Fault flag raises receiver/error request
// - Fault clears SPI enable bit
// - Fault clears master select bit
// - SS disabled: low SS sets nothing
// - Fault clears: status read then control write
// - Data write during transfer sets collision
// - Collision: no request, transfer continues
// - Collision clears: status then data access
// - Overrun keeps first byte, drops later
// - Overrun is never flagged
// - Slave: SS high midbyte sets error
// - Error no request; enable write 0 clears
// - Transfer end sets flag, transmitter request
// - Fault request only while SS enabled
`timescale 1ns/1ps
`include "spief_regs.vh"
`default_nettype none
module spief_top (
    input wire CLK,
    input wire SYS_RST,
    input wire SS_N_PIN,
    input wire SCK_PIN,
    input wire CTL_WR,
    input wire [7:0] CTL_WDATA,
    input wire STA_RD,
    input wire DATA_WR,
    input wire DATA_RD,
    input wire XFER_BUSY,
    input wire XFER_DONE,
    input wire [7:0] RX_BYTE,
    output reg [7:0] STA_RDATA,
    output reg [7:0] DATA_RDATA,
    output wire SPI_ENABLE,
    output wire MASTER_SELECT,
    output wire SS_DISABLE,
    output wire XFER_ABORT,
    output wire TX_IRQ,
    output wire RXERR_IRQ,
    output wire SPI_IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Each one resets to the idle level of its own pin, so the edge
    // detectors behind them see no false edge when reset is released
    wire ss_n_s; // Synchronised slave select, active low
    wire sck_s; // Synchronised serial clock, kept for edge use
    spief_sync #(.RST_LEVEL(`SPIEF_SS_IDLE)) u_ss (
        .clk(CLK),
        .rst(SYS_RST),
        .d(SS_N_PIN),
        .q(ss_n_s)
    );
    spief_sync #(.RST_LEVEL(`SPIEF_SCK_IDLE)) u_sck (
        .clk(CLK),
        .rst(SYS_RST),
        .d(SCK_PIN),
        .q(sck_s)
    );
    ////////////////////////////////////////////////////////////////////////
    // State
    reg spi_enable_bit_r; // Control: enable
    reg master_select_bit_r; // Control: master mode
    reg slave_select_disable_bit_r; // Control: SS as plain I/O
    reg mode_fault_flag_r; // Sticky fault
    reg write_collision_flag_r; // Sticky collision
    reg slave_select_error_flag_r; // Sticky SS error
    reg transfer_complete_flag_r; // Sticky done
    reg mode_fault_flag_armed_r; // Status read saw fault set
    reg write_collision_flag_armed_r; // Status accessed with collision set
    reg [7:0] spi_data_reg_r; // Receive buffer
    reg ss_n_d_r; // Previous SS for edge detection
    reg sck_d_r; // Previous SCK
    reg sck_seen_r; // SCK moved in the current slave byte
    // Control write bit positions differ from the status layout: enable 6, SS disable 5, master 4
    wire ctl_en_w = CTL_WDATA[`SPIEF_CTL_EN_BIT];
    wire ctl_master_select_bit_w = CTL_WDATA[`SPIEF_CTL_MASTER_SELECT_BIT_BIT];
    wire ctl_slave_select_disable_bit_w = CTL_WDATA[`SPIEF_CTL_SLAVE_SELECT_DISABLE_BIT_BIT];
    // Fault detection: master, SS used, SS low
    wire mode_fault_flag_set = spi_enable_bit_r & master_select_bit_r
                  & ~slave_select_disable_bit_r & ~ss_n_s;
    // Rising edge of the synchronised select; the delay register resets to idle
    wire ss_rise = ss_n_s & ~ss_n_d_r;
    // Slave byte still in progress when SS rises
    wire slave_select_error_flag_set = spi_enable_bit_r & ~master_select_bit_r & ss_rise
                   & (XFER_BUSY | sck_seen_r) & ~XFER_DONE;
    wire en_clear = CTL_WR & ~ctl_en_w;
    ////////////////////////////////////////////////////////////////////////
    // Control register; fault overrides software write
    always @(posedge CLK) begin
        if (SYS_RST) begin
            spi_enable_bit_r <= `SPIEF_CTL_EN_RST;
            master_select_bit_r <= `SPIEF_CTL_MASTER_SELECT_BIT_RST;
            slave_select_disable_bit_r <= `SPIEF_CTL_SLAVE_SELECT_DISABLE_BIT_RST;
        end else begin
            if (CTL_WR) begin
                // Software may enable again; blocked while fault pending
                spi_enable_bit_r <= ctl_en_w & ~mode_fault_flag_r;
                master_select_bit_r <= ctl_master_select_bit_w;
                slave_select_disable_bit_r <= ctl_slave_select_disable_bit_w;
            end
            if (mode_fault_flag_set) begin
                spi_enable_bit_r <= 1'b0;
                master_select_bit_r <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Mode fault flag: set wins over the read-then-write clear
    always @(posedge CLK) begin
        if (SYS_RST) begin
            mode_fault_flag_r <= 1'b0;
            mode_fault_flag_armed_r <= 1'b0;
        end else begin
            if (STA_RD && mode_fault_flag_r)
                mode_fault_flag_armed_r <= 1'b1;
            else if (CTL_WR)
                mode_fault_flag_armed_r <= 1'b0;
            if (mode_fault_flag_set)
                mode_fault_flag_r <= 1'b1;
            else if (CTL_WR && mode_fault_flag_armed_r)
                mode_fault_flag_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Write collision: never touches the transfer
    // The written byte itself is the shifter's business, not this block's
    always @(posedge CLK) begin
        if (SYS_RST) begin
            write_collision_flag_r <= 1'b0;
            write_collision_flag_armed_r <= 1'b0;
        end else begin
            if (STA_RD && write_collision_flag_r)
                write_collision_flag_armed_r <= 1'b1;
            else if (DATA_WR || DATA_RD)
                write_collision_flag_armed_r <= 1'b0;
            if (DATA_WR && XFER_BUSY)
                write_collision_flag_r <= 1'b1;
            else if ((DATA_WR || DATA_RD) && write_collision_flag_armed_r)
                write_collision_flag_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Slave select error, cleared by enable write of 0
    always @(posedge CLK) begin
        if (SYS_RST) begin
            slave_select_error_flag_r <= 1'b0;
            ss_n_d_r <= `SPIEF_SS_IDLE;
            sck_d_r <= `SPIEF_SCK_IDLE;
            sck_seen_r <= 1'b0;
        end else begin
            ss_n_d_r <= ss_n_s;
            sck_d_r <= sck_s;
            // Track clock activity inside a slave byte
            if (XFER_DONE || ss_n_s || en_clear)
                sck_seen_r <= 1'b0;
            else if (sck_s != sck_d_r)
                sck_seen_r <= 1'b1;
            if (slave_select_error_flag_set)
                slave_select_error_flag_r <= 1'b1;
            else if (en_clear)
                slave_select_error_flag_r <= 1'b0;
        end
    end
    // Enable write of 0 resets the shifter state machine
    // Combinational on purpose: the shifter must stop in the same cycle in
    // which the enable bit falls, so it never runs one edge past a fault
    assign XFER_ABORT = en_clear | mode_fault_flag_set;
    ////////////////////////////////////////////////////////////////////////
    // Transfer complete and receive buffer; overrun silently drops
    // Limitation: software cannot tell that bytes were lost, since overrun
    // leaves no trace in the status byte
    always @(posedge CLK) begin
        if (SYS_RST) begin
            transfer_complete_flag_r <= 1'b0;
            spi_data_reg_r <= `SPIEF_DATA_RST;
        end else begin
            if (XFER_DONE) begin
                transfer_complete_flag_r <= 1'b1;
                // Only first byte after clear is kept
                if (!transfer_complete_flag_r)
                    spi_data_reg_r <= RX_BYTE;
            end else if (DATA_RD && transfer_complete_flag_r) begin
                // Read of data clears done flag
                transfer_complete_flag_r <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data registers
    always @(posedge CLK) begin
        if (SYS_RST) begin
            STA_RDATA <= 8'h00;
            DATA_RDATA <= `SPIEF_DATA_RST;
        end else begin
            STA_RDATA <= 8'h00;
            STA_RDATA[`SPIEF_STA_TC_BIT] <= transfer_complete_flag_r;
            STA_RDATA[`SPIEF_STA_WRITE_COLLISION_FLAG_BIT] <= write_collision_flag_r;
            STA_RDATA[`SPIEF_STA_SLAVE_SELECT_ERROR_FLAG_BIT] <= slave_select_error_flag_r;
            STA_RDATA[`SPIEF_STA_MODE_FAULT_FLAG_BIT] <= mode_fault_flag_r;
            DATA_RDATA <= spi_data_reg_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Requests: collision and SS error never request
    // Built only from flops, so the request lines do not glitch
    assign TX_IRQ = transfer_complete_flag_r;
    assign RXERR_IRQ = mode_fault_flag_r & ~slave_select_disable_bit_r;
    assign SPI_IRQ = TX_IRQ | RXERR_IRQ;
    assign SPI_ENABLE = spi_enable_bit_r;
    assign MASTER_SELECT = master_select_bit_r;
    assign SS_DISABLE = slave_select_disable_bit_r;
endmodule // spief_top
`default_nettype wire

// file: verif/spief_peer.sv
// Far-side SPI party: drives slave select and serial clock pins.
// Assumes the bench calls its tasks; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module spief_peer (
    output logic ss_n,
    output logic sck
);
    // Deselected and still at start
    initial {ss_n, sck} = 2'h2;
    // Holds select at a level
    task automatic sel(input logic lvl);
        ss_n = lvl;
    endtask
    // Frame cut short: select rises before the byte is over
    task automatic cut_frame(input int edges);
        ss_n = 1'b0;
        repeat (edges) #200 sck = ~sck;
        #200 {ss_n, sck} = 2'h2;
    endtask
endmodule // spief_peer
`default_nettype wire

// file: verif/spief_checker.sv
// Port checker of the SPI error and interrupt flag block.
// Assumes it is bound to spief_top with one-cycle strobes on CLK.
`timescale 1ns/1ps
`default_nettype none
module spief_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SS_N_PIN,
    input wire logic CTL_WR,
    input wire logic [7:0] CTL_WDATA,
    input wire logic STA_RD,
    input wire logic DATA_WR,
    input wire logic XFER_BUSY,
    input wire logic XFER_DONE,
    input wire logic [7:0] STA_RDATA,
    input wire logic SPI_ENABLE,
    input wire logic MASTER_SELECT,
    input wire logic SS_DISABLE,
    input wire logic XFER_ABORT,
    input wire logic TX_IRQ,
    input wire logic RXERR_IRQ,
    input wire logic SPI_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////
    // Pin low long enough to pass the two-flop synchroniser
    sequence s_clash; (SPI_ENABLE && MASTER_SELECT && !SS_DISABLE && !SS_N_PIN) [*3]; endsequence
    // Status read taken while the fault stands arms the clear
    sequence s_arm; STA_RD && RXERR_IRQ; endsequence
    property p_set; s_clash |-> ##[0:2] RXERR_IRQ; endproperty
    // A request that appears only because the select disable fell is not a new fault
    property p_side; $rose(RXERR_IRQ) && $stable(SS_DISABLE) |-> !SPI_ENABLE && !MASTER_SELECT;
    endproperty
    property p_clr; s_arm ##[1:4] CTL_WR |=> !RXERR_IRQ; endproperty
    property p_write_collision_flag; DATA_WR && XFER_BUSY |=> ##1 STA_RDATA[6]; endproperty
    property p_quiet; DATA_WR && XFER_BUSY && !XFER_DONE && !SPI_IRQ && SS_DISABLE |=> !SPI_IRQ;
    endproperty
    property p_done; XFER_DONE && !CTL_WR |=> TX_IRQ; endproperty
    property p_gate; SS_DISABLE |-> !RXERR_IRQ; endproperty
    property p_or; SPI_IRQ == (TX_IRQ || RXERR_IRQ); endproperty
    property p_abort; CTL_WR && !CTL_WDATA[6] |-> XFER_ABORT; endproperty
    a_set: assert property (p_set) else $error("fault not raised");
    a_side: assert property (p_side) else $error("fault left control set");
    a_clr: assert property (p_clr) else $error("fault not cleared");
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");
    a_quiet: assert property (p_quiet) else $error("collision raised a request");
    a_done: assert property (p_done) else $error("done request missing");
    a_gate: assert property (p_gate) else $error("fault request not gated");
    a_or: assert property (p_or) else $error("merged request wrong");
    a_abort: assert property (p_abort) else $error("shifter not reset on disable");
endmodule // spief_checker
bind spief_top spief_checker spief_checker_i (.CLK, .SYS_RST, .SS_N_PIN, .CTL_WR, .CTL_WDATA,
    .STA_RD, .DATA_WR, .XFER_BUSY, .XFER_DONE, .STA_RDATA, .SPI_ENABLE, .MASTER_SELECT,
    .SS_DISABLE, .XFER_ABORT, .TX_IRQ, .RXERR_IRQ, .SPI_IRQ);
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the SPI error and interrupt flag block.
// Assumes strobes are taken at CLK rising edges; the peer drives the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, ctl_wr = 0, sta_rd = 0, data_wr = 0, data_rd = 0, busy = 0, done = 0;
    logic [7:0] wdata = 8'h00, rx = 8'h00, sta, dat, lv;
    logic en, master_select_bit, slave_select_disable_bit, txi, rxi, irq, ss_n, sck, abort;
    logic [7:0] n_abort = 8'h00; // Shifter reset pulses seen at rising edges
    int n_mismatch = 0, tests_run = 0;
    // Levels packed: enable, master, select disable, tx, rx/error, merged
    assign lv = {2'h0, en, master_select_bit, slave_select_disable_bit, txi, rxi, irq};
    spief_top spief_top_i (.CLK(clk), .SYS_RST(rst), .SS_N_PIN(ss_n), .SCK_PIN(sck),
        .CTL_WR(ctl_wr), .CTL_WDATA(wdata), .STA_RD(sta_rd), .DATA_WR(data_wr),
        .DATA_RD(data_rd), .XFER_BUSY(busy), .XFER_DONE(done), .RX_BYTE(rx), .STA_RDATA(sta),
        .DATA_RDATA(dat), .SPI_ENABLE(en), .MASTER_SELECT(master_select_bit), .SS_DISABLE(slave_select_disable_bit),
        .XFER_ABORT(abort), .TX_IRQ(txi), .RXERR_IRQ(rxi), .SPI_IRQ(irq));
    spief_peer spief_peer_i (.ss_n(ss_n), .sck(sck));
    initial forever #25 clk = ~clk;
    // Counts shifter reset pulses; the pulse is combinational, so it is read at the edge
    always @(posedge clk) if (!rst && abort === 1'b1) n_abort <= n_abort + 8'h01;
    ////////////////////////////////////////////////////////////////
    // One-cycle strobe, raised just after an edge
    task automatic strobe(ref logic s);
        @(posedge clk) #2 s = 1;
        @(posedge clk) #2 s = 0;
    endtask
    task automatic ctl_write(input logic [7:0] d);
        wdata = d;
        strobe(ctl_wr);
    endtask
    // Lets edges pass so registered answers settle
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic sta_read;
        strobe(sta_rd);
        wait_n(2);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        wait_n(2);
        rst = 0;
        chk(lv, 8'h00);
        ctl_write(8'h50);
        spief_peer_i.sel(0);
        wait_n(6);
        chk(lv, 8'h03);
        ctl_write(8'h20);
        wait_n(1);
        chk(lv, 8'h08);
        ctl_write(8'h00);
        wait_n(1);
        chk(lv, 8'h03);
        sta_read;
        chk(sta, 8'h10);
        spief_peer_i.sel(1);
        ctl_write(8'h00);
        wait_n(1);
        chk(lv, 8'h00);
        ctl_write(8'h50);
        wait_n(1);
        chk(lv, 8'h30);
        chk(n_abort, 8'h04);
        $display("test done: mode fault");
        ctl_write(8'h70);
        spief_peer_i.sel(0);
        wait_n(6);
        chk(lv, 8'h38);
        spief_peer_i.sel(1);
        busy = 1;
        strobe(data_wr);
        sta_read;
        chk(sta, 8'h40);
        chk(lv, 8'h38);
        strobe(data_rd);
        sta_read;
        chk(sta, 8'h00);
        busy = 0;
        $display("test done: collision");
        rx = 8'hA5;
        strobe(done);
        rx = 8'h3C;
        strobe(done);
        wait_n(1);
        chk(lv, 8'h3D);
        strobe(data_rd);
        wait_n(2);
        chk(dat, 8'hA5);
        sta_read;
        chk(sta, 8'h00);
        $display("test done: overrun");
        ctl_write(8'h40);
        busy = 1;
        spief_peer_i.cut_frame(4);
        sta_read;
        chk(sta, 8'h20);
        chk(lv, 8'h20);
        ctl_write(8'h00);
        busy = 0;
        sta_read;
        chk(sta, 8'h00);
        ctl_write(8'h40);
        spief_peer_i.cut_frame(0);
        sta_read;
        chk(sta, 8'h00);
        spief_peer_i.cut_frame(3);
        sta_read;
        chk(sta, 8'h20);
        chk(n_abort, 8'h05);
        $display("test done: select error");
        end_of_test;
    end
    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #100000;
        n_mismatch++;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
